// [verilog/mms_stat_bank.sv]
// Ethernet MIB statistics counter bank with host register access.
// Assumes frame reports and events come from logic on the same clock.
//
// Summary of operation
// (R1) Registers are reached through a 256-byte I/O window and a 512-byte memory window, each enabled.
// (R2) The host never accesses wider than a register, so a half-slot write touches one counter only.
// (R3) The received broadcast frame counter counts good frames sent to the all-ones address.
// (R4) Frames too long, with FCS, length or alignment errors, or lost inside are not counted.
// (R5) The 16-bit received broadcast frame counter wraps to zero after 0xffff.
// (R6) Reaching 0xc000 on the received broadcast frame counter raises the update flag.
// (R7) The received broadcast frame counter runs only with global enable set and its mask clear.
// (R8) The sent broadcast frame counter counts good all-ones frames and no other multicast.
// (R9) The 16-bit sent broadcast frame counter wraps to zero after 0xffff.
// (R10) Reaching 0xc000 on the sent broadcast frame counter raises the update flag.
// (R11) The sent broadcast frame counter runs only with global enable set and its mask clear.
// (R12) The received broadcast octet counter adds data and pad octets of good broadcast frames.
// (R13) Every octet counter includes the four VLAN tag octets however the tag was handled.
// (R14) The received broadcast octet counter wraps after all ones and flags at three quarters.
// (R15) Two 16-bit counters in one slot sit first in the low lanes, second in the high lanes.
`include "mms_stat_map.svh"

module mms_stat_bank #(
    parameter int NUM_CNT = `MMS_NUM_CNT
) (
    input wire logic clk,
    input wire logic rst_n,
    input mms_stat_pkg::mms_host_req_t host_req,
    output mms_stat_pkg::mms_host_rsp_t host_rsp,
    input wire logic io_window_en,
    input wire logic mem_window_en,
    input wire logic global_counting_enable,
    input wire logic [NUM_CNT-1:0] per_counter_mask_register,
    input mms_stat_pkg::mms_frame_t rx_frame,
    input mms_stat_pkg::mms_frame_t tx_frame,
    input mms_stat_pkg::mms_evt_t side_evt,
    output logic stats_threshold_irq_flag
);
    import mms_stat_pkg::*;

    // ==========================================================
    // Counter layout, one entry per counter
    localparam logic [7:0] SLOT [NUM_CNT] = '{
        // Received side
        `MMS_OFS_RX_OCT, // 0 all octets
        `MMS_OFS_RX_MC_OCT, // 1 multicast octets
        `MMS_OFS_RX_BC_OCT, // 2 broadcast octets
        `MMS_OFS_RX_FRM, // 3 good frames
        `MMS_OFS_RX_MC_FRM, // 4 multicast frames
        `MMS_OFS_RX_BC_FRM, // 5 broadcast frames
        `MMS_OFS_RX_PAUSE, // 6 pause frames
        `MMS_OFS_RX_LEN_ERR, // 7 oversize
        `MMS_OFS_RX_LEN_ERR, // 8 length field
        `MMS_OFS_RX_ERR, // 9 check sequence
        `MMS_OFS_RX_ERR, // 10 internal loss

        // Sent side
        `MMS_OFS_TX_OCT, // 11 all octets
        `MMS_OFS_TX_MC_OCT, // 12 multicast octets
        `MMS_OFS_TX_BC_OCT, // 13 broadcast octets
        `MMS_OFS_TX_FRM, // 14 good frames
        `MMS_OFS_TX_MC_FRM, // 15 multicast frames
        `MMS_OFS_TX_DEFER, // 16 deferred
        `MMS_OFS_TX_LATE, // 17 late collision
        `MMS_OFS_TX_MULTI, // 18 multiple collisions
        `MMS_OFS_TX_SINGLE, // 19 single collision
        `MMS_OFS_TX_BC_FRM, // 20 broadcast frames
        `MMS_OFS_TX_CRS, // 21 carrier loss
        `MMS_OFS_TX_CRS, // 22 pause frames
        `MMS_OFS_TX_ABORT, // 23 collision abort
        `MMS_OFS_TX_ABORT // 24 excess deferral
    };

    // Lane of each counter inside its slot
    localparam logic HILANE [NUM_CNT] = '{
        // Received side
        `MMS_LANE_LO, // 0
        `MMS_LANE_LO, // 1
        `MMS_LANE_LO, // 2
        `MMS_LANE_LO, // 3
        `MMS_LANE_LO, // 4
        `MMS_LANE_LO, // 5
        `MMS_LANE_LO, // 6
        `MMS_LANE_LO, // 7
        `MMS_LANE_HI, // 8
        `MMS_LANE_LO, // 9
        `MMS_LANE_HI, // 10

        // Sent side
        `MMS_LANE_LO, // 11
        `MMS_LANE_LO, // 12
        `MMS_LANE_LO, // 13
        `MMS_LANE_LO, // 14
        `MMS_LANE_LO, // 15
        `MMS_LANE_LO, // 16
        `MMS_LANE_LO, // 17
        `MMS_LANE_LO, // 18
        `MMS_LANE_LO, // 19
        `MMS_LANE_LO, // 20
        `MMS_LANE_LO, // 21
        `MMS_LANE_HI, // 22
        `MMS_LANE_LO, // 23
        `MMS_LANE_HI // 24
    };

    // Width of each counter
    localparam int WID [NUM_CNT] = '{
        // Received side
        32, // 0
        32, // 1
        32, // 2
        32, // 3
        32, // 4
        16, // 5
        16, // 6
        16, // 7
        16, // 8
        16, // 9
        16, // 10

        // Sent side
        32, // 11
        32, // 12
        32, // 13
        32, // 14
        32, // 15
        32, // 16
        32, // 17
        32, // 18
        32, // 19
        16, // 20
        16, // 21
        16, // 22
        16, // 23
        16 // 24
    };

    // ==========================================================
    // Registered state
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } mms_bank_st_t;

    mms_bank_st_t st_ff;
    mms_bank_st_t nxt_st;

    // Frame classes per direction
    mms_class_t rx_cls;
    mms_class_t tx_cls;

    // Per-counter amounts, values, decodes and gates
    logic [31:0] amt [NUM_CNT];
    logic [31:0] val [NUM_CNT];
    logic [31:0] lane_val [NUM_CNT];
    logic [NUM_CNT-1:0] hit;
    logic [NUM_CNT-1:0] sel;
    logic [NUM_CNT-1:0] cnt_en;

    // Host decode
    logic win_ok;
    logic wr_go;
    logic [31:0] rd_mux;

    // ==========================================================
    // Frame classification per direction
    mms_frame_classify u_rx_class (
        .frame (rx_frame),
        .cls (rx_cls)
    );

    mms_frame_classify u_tx_class (
        .frame (tx_frame),
        .cls (tx_cls)
    );

    // ==========================================================
    // Amount added to each counter this cycle
    always_comb begin
        // Received frame classes
        amt[0] = rx_cls.octets; // R13
        amt[1] = rx_cls.mcast ? rx_cls.octets : 32'h0;
        amt[2] = rx_cls.bcast ? rx_cls.octets : 32'h0; // R12
        amt[3] = 32'(rx_cls.ok);
        amt[4] = 32'(rx_cls.mcast);
        amt[5] = 32'(rx_cls.bcast); // R3

        // Received single events
        amt[6] = 32'(side_evt.rx_pause);
        amt[7] = 32'(side_evt.rx_oversize);
        amt[8] = 32'(side_evt.rx_len_field);
        amt[9] = 32'(side_evt.rx_fcs);
        amt[10] = 32'(side_evt.rx_loss);

        // Sent frame classes
        amt[11] = tx_cls.octets; // R13
        amt[12] = tx_cls.mcast ? tx_cls.octets : 32'h0;
        amt[13] = tx_cls.bcast ? tx_cls.octets : 32'h0;
        amt[14] = 32'(tx_cls.ok);
        amt[15] = 32'(tx_cls.mcast);

        // Sent single events, with the broadcast frame count in its slot order
        amt[16] = 32'(side_evt.tx_deferred);
        amt[17] = 32'(side_evt.tx_late_coll);
        amt[18] = 32'(side_evt.tx_multi_coll);
        amt[19] = 32'(side_evt.tx_single_coll);
        amt[20] = 32'(tx_cls.bcast); // R8
        amt[21] = 32'(side_evt.tx_carrier_loss);
        amt[22] = 32'(side_evt.tx_pause);
        amt[23] = 32'(side_evt.tx_xs_abort);
        amt[24] = 32'(side_evt.tx_xs_defer);
    end

    // ==========================================================
    // Window decode: I/O space holds 256 bytes, memory 512
    always_comb begin
        if (host_req.io_space) begin
            win_ok = io_window_en && (10'(host_req.addr) < `MMS_IO_WIN_BYTES); // R1
        end else begin
            win_ok = mem_window_en && (10'(host_req.addr) < `MMS_MEM_WIN_BYTES); // R1
        end
        // Only writes inside an enabled window reach a counter
        wr_go = host_req.req && host_req.wr && win_ok;
    end

    // ==========================================================
    // Counting gate: global enable set and own mask bit clear
    assign cnt_en = {NUM_CNT{global_counting_enable}}
        & ~per_counter_mask_register; // R7 R11

    // ==========================================================
    // Counter array
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        logic [WID[i]-1:0] q_w;
        logic [WID[i]/8-1:0] be_w;
        logic [WID[i]-1:0] data_w;

        // Slot match on the word address
        assign sel[i] = (host_req.addr[8:2] == {1'b0, SLOT[i][7:2]});

        // Lane steering for half-slot counters
        if (WID[i] == 32) begin : g_word
            assign be_w = host_req.be;
            assign data_w = host_req.wdata;
        end else begin : g_half
            assign be_w = HILANE[i] ? host_req.be[3:2] : host_req.be[1:0]; // R15 R2
            assign data_w = HILANE[i] ? host_req.wdata[31:16]
                : host_req.wdata[15:0]; // R15
        end

        mms_stat_counter #(
            .W (WID[i])
        ) u_cnt (
            .clk (clk),
            .rst_n (rst_n),
            .en (cnt_en[i]),
            .amt (amt[i]),
            .wr_en (wr_go && sel[i]),
            .wr_be (be_w),
            .wr_data (data_w),
            .value (q_w),
            .hit (hit[i])
        );

        assign val[i] = 32'(q_w);

        // Place half-slot counters in their byte lanes for the read mux
        assign lane_val[i] = HILANE[i] ? {val[i][15:0], 16'h0} : val[i]; // R15
    end

    // ==========================================================
    // Read mux: unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0;
        for (int i = 0; i < NUM_CNT; i++) begin
            if (sel[i]) begin
                rd_mux = rd_mux | lane_val[i];
            end
        end
    end

    // ==========================================================
    // Next state: answer, read data and update pulse
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = host_req.req;
        if (host_req.req && !host_req.wr) begin
            nxt_st.rdata = win_ok ? rd_mux : 32'h0;
        end
        // One pulse however many counters cross in the same cycle
        nxt_st.irq = |hit; // R6 R10 R14
    end

    assign host_rsp.ack = st_ff.ack;
    assign host_rsp.rdata = st_ff.rdata;
    assign stats_threshold_irq_flag = st_ff.irq;

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : mms_stat_bank

// [verilog/mms_stat_map.svh]
// Offsets, lane choices, reset values and thresholds of the MIB counter bank.
// Assumes byte addresses relative to the start of either host window.
`ifndef MMS_STAT_MAP_SVH
`define MMS_STAT_MAP_SVH

// ==========================================================
// Window sizes
`define MMS_IO_WIN_BYTES 10'h100
`define MMS_MEM_WIN_BYTES 10'h200

// ==========================================================
// Counter slot offsets
`define MMS_OFS_RX_OCT 8'ha8
`define MMS_OFS_RX_MC_OCT 8'hac
`define MMS_OFS_RX_BC_OCT 8'hb0
`define MMS_OFS_RX_FRM 8'hb4
`define MMS_OFS_RX_MC_FRM 8'hb8
`define MMS_OFS_RX_BC_FRM 8'hbc
`define MMS_OFS_RX_PAUSE 8'hc4
`define MMS_OFS_RX_LEN_ERR 8'hc8
`define MMS_OFS_RX_ERR 8'hcc
`define MMS_OFS_TX_OCT 8'hd0
`define MMS_OFS_TX_MC_OCT 8'hd4
`define MMS_OFS_TX_BC_OCT 8'hd8
`define MMS_OFS_TX_FRM 8'hdc
`define MMS_OFS_TX_MC_FRM 8'he0
`define MMS_OFS_TX_DEFER 8'he4
`define MMS_OFS_TX_LATE 8'he8
`define MMS_OFS_TX_MULTI 8'hec
`define MMS_OFS_TX_SINGLE 8'hf0
`define MMS_OFS_TX_BC_FRM 8'hf4
`define MMS_OFS_TX_CRS 8'hf8
`define MMS_OFS_TX_ABORT 8'hfc

// ==========================================================
// Field positions, values and counts
`define MMS_LANE_LO 1'b0
`define MMS_LANE_HI 1'b1
`define MMS_CNT_RST 32'h0000_0000
`define MMS_THR_TOP 2'b11
`define MMS_BCAST_ADDR 48'hffff_ffff_ffff
`define MMS_GROUP_BIT 40
`define MMS_VLAN_OCTETS 32'h0000_0004
`define MMS_NUM_CNT 25

`endif

// [verilog/mms_stat_pkg.sv]
// Types shared by the MIB counter bank and its helpers.
// Assumes mms_stat_map.svh is on the include path.
package mms_stat_pkg;

    // ==========================================================
    // Host access carriers
    typedef struct packed {
        logic req;
        logic io_space;
        logic wr;
        logic [8:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } mms_host_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } mms_host_rsp_t;

    // ==========================================================
    // Frame completion report from the MAC datapath
    typedef struct packed {
        logic done;
        logic [47:0] dst;
        logic [15:0] octets;
        logic vlan_handled;
        logic too_long;
        logic fcs_err;
        logic len_err;
        logic align_err;
        logic lost;
    } mms_frame_t;

    // Single-event sources of the remaining counters
    typedef struct packed {
        logic rx_pause;
        logic rx_oversize;
        logic rx_len_field;
        logic rx_fcs;
        logic rx_loss;
        logic tx_deferred;
        logic tx_late_coll;
        logic tx_multi_coll;
        logic tx_single_coll;
        logic tx_carrier_loss;
        logic tx_pause;
        logic tx_xs_abort;
        logic tx_xs_defer;
    } mms_evt_t;

    typedef struct packed {
        logic ok;
        logic mcast;
        logic bcast;
        logic [31:0] octets;
    } mms_class_t;

endpackage : mms_stat_pkg

// [verilog/mms_frame_classify.sv]
// Sorts one completed frame into ok, multicast and broadcast classes.
// Assumes a one-cycle done pulse with all fields valid in that cycle.
`include "mms_stat_map.svh"

module mms_frame_classify (
    input mms_stat_pkg::mms_frame_t frame,
    output mms_stat_pkg::mms_class_t cls
);
    import mms_stat_pkg::*;

    logic good;

    // ==========================================================
    // Classification
    always_comb begin
        good = frame.done && !frame.too_long && !frame.fcs_err && !frame.len_err
            && !frame.align_err && !frame.lost; // R4
        cls.ok = good;
        cls.bcast = good && (frame.dst == `MMS_BCAST_ADDR); // R3 R8
        cls.mcast = good && frame.dst[`MMS_GROUP_BIT] && !cls.bcast; // R8
        // Tag octets counted whether or not the MAC handled the tag
        cls.octets = good ? (32'(frame.octets)
            + (frame.vlan_handled ? `MMS_VLAN_OCTETS : 32'h0)) : 32'h0; // R12 R13
    end

endmodule : mms_frame_classify

// [verilog/mms_stat_counter.sv]
// One wrapping statistics counter with byte-lane host write.
// Assumes amt is zero outside a counting event.
`include "mms_stat_map.svh"

module mms_stat_counter #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [31:0] amt,
    input wire logic wr_en,
    input wire logic [W/8-1:0] wr_be,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] value,
    output logic hit
);
    import mms_stat_pkg::*;

    localparam logic [W-1:0] THR = {`MMS_THR_TOP, {(W-2){1'b0}}};

    typedef struct packed {
        logic [W-1:0] cnt;
    } mms_cnt_st_t;

    mms_cnt_st_t st_ff;
    mms_cnt_st_t nxt_st;
    logic [W-1:0] sum;
    logic wrapped;

    // ==========================================================
    // Count, wrap, threshold and host write
    always_comb begin
        nxt_st = st_ff;
        sum = st_ff.cnt + amt[W-1:0]; // R5 R9 R14
        wrapped = sum < st_ff.cnt;
        hit = 1'b0;
        if (en && amt != 32'h0) begin // R7 R11
            nxt_st.cnt = sum;
            // Crossing the mark, also when a large add wraps past it
            hit = (st_ff.cnt < THR) && (wrapped || sum >= THR); // R6 R10 R14
        end
        // Host write wins over a count in the same byte lane
        for (int b = 0; b < W / 8; b++) begin
            if (wr_en && wr_be[b]) begin
                nxt_st.cnt[8*b +: 8] = wr_data[8*b +: 8];
            end
        end
    end

    assign value = st_ff.cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{cnt: W'(`MMS_CNT_RST)};
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : mms_stat_counter

// [tb/mms_stat_bank_properties.sv]
// Checker for the MIB counter bank, seeing only its ports.
// Assumes one clock domain and the bind at the foot of this file.
module mms_stat_bank_properties #(
    parameter int NUM_CNT = 25
) (
    input wire logic clk,
    input wire logic rst_n,
    input mms_stat_pkg::mms_host_req_t host_req,
    input mms_stat_pkg::mms_host_rsp_t host_rsp,
    input wire logic io_window_en,
    input wire logic mem_window_en,
    input wire logic global_counting_enable,
    input wire logic [NUM_CNT-1:0] per_counter_mask_register,
    input mms_stat_pkg::mms_frame_t rx_frame,
    input mms_stat_pkg::mms_frame_t tx_frame,
    input mms_stat_pkg::mms_evt_t side_evt,
    input wire logic stats_threshold_irq_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    import mms_stat_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ====================
    // Helpers
    logic rd_req;
    logic any_evt;
    assign rd_req = host_req.req && !host_req.wr;
    assign any_evt = rx_frame.done || tx_frame.done || (|side_evt);

    // ====================
    // Host access
    ack_follows_req_a: assert property (host_req.req |=> host_rsp.ack)
        else $error("ack missing after request");
    ack_only_req_a: assert property (!host_req.req |=> !host_rsp.ack)
        else $error("ack without request");
    rdata_holds_a: assert property (!rd_req |=> $stable(host_rsp.rdata))
        else $error("read data moved without a read");
    upper_half_zero_a: assert property (rd_req && host_req.addr[8] |=> host_rsp.rdata == '0)
        else $error("read above 0x100 not zero");
    gap_slot_zero_a: assert property (rd_req && host_req.addr == 9'h0c0
        |=> host_rsp.rdata == '0)
        else $error("unmapped slot read not zero");
    mem_off_zero_a: assert property (rd_req && !host_req.io_space && !mem_window_en
        |=> host_rsp.rdata == '0)
        else $error("disabled memory window answered data");
    io_off_zero_a: assert property (rd_req && host_req.io_space && !io_window_en
        |=> host_rsp.rdata == '0)
        else $error("disabled io window answered data");

    // ====================
    // Counting and flag
    stopped_silent_a: assert property (!global_counting_enable
        |=> !stats_threshold_irq_flag)
        else $error("flag raised while counting stopped");
    masked_silent_a: assert property (&per_counter_mask_register
        |=> !stats_threshold_irq_flag)
        else $error("flag raised with all counters masked");
    flag_has_cause_a: assert property (stats_threshold_irq_flag |-> $past(any_evt))
        else $error("flag without a count event");

    // Main scenarios
    cover property (rd_req ##1 host_rsp.ack);
    cover property (stats_threshold_irq_flag);
    cover property (rx_frame.done && global_counting_enable);
endmodule : mms_stat_bank_properties

bind mms_stat_bank mms_stat_bank_properties #(.NUM_CNT(NUM_CNT)) u_props (
    .clk(clk), .rst_n(rst_n), .host_req(host_req), .host_rsp(host_rsp),
    .io_window_en(io_window_en), .mem_window_en(mem_window_en),
    .global_counting_enable(global_counting_enable),
    .per_counter_mask_register(per_counter_mask_register),
    .rx_frame(rx_frame), .tx_frame(tx_frame), .side_evt(side_evt),
    .stats_threshold_irq_flag(stats_threshold_irq_flag)
);

// [tb/mms_host_model.sv]
// Host model: single-cycle register reads and writes on the bank.
// Assumes callers enter just after a rising edge of clk.
module mms_host_model (
    input wire logic clk,
    output mms_stat_pkg::mms_host_req_t host_req,
    input mms_stat_pkg::mms_host_rsp_t host_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import mms_stat_pkg::*;

    // Idle bus at time zero
    initial host_req = '0;

    // One access, answer taken after the following edge
    task automatic acc(input logic io, input logic wr, input logic [8:0] addr,
                       input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] rd);
        host_req = '{1'b1, io, wr, addr, be, wd};
        @(posedge clk);
        #1;
        host_req.req = 1'b0;
        host_req.addr = ~addr;
        host_req.wdata = ~wd;
        rd = host_rsp.ack ? host_rsp.rdata : 32'hdead_beef;
        // Idle edge so that a following call never rewrites req in this time step
        @(posedge clk);
        #1;
    endtask : acc
endmodule : mms_host_model

// [tb/testbench.sv]
// Self-checking bench for the MIB counter bank.
// Assumes the package, design, host model and checker are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mms_stat_pkg::*;
    localparam logic [47:0] BC = 48'hffff_ffff_ffff;
    localparam logic [47:0] MC = 48'h0100_5e00_0001;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic io_en = 1'b1;
    logic mem_en = 1'b1;
    logic gce = 1'b1;
    logic [24:0] mask = '0;
    mms_host_req_t host_req;
    mms_host_rsp_t host_rsp;
    mms_frame_t rx_frame = '0;
    mms_frame_t tx_frame = '0;
    mms_evt_t side_evt = '0;
    logic irq;
    logic [31:0] rd;
    int fails = 0;
    int samples_checked = 0;
    int irq_cnt = 0;

    // ====================
    // Structure
    mms_stat_bank u_dut (
        .clk(clk), .rst_n(rst_n), .host_req(host_req), .host_rsp(host_rsp),
        .io_window_en(io_en), .mem_window_en(mem_en), .global_counting_enable(gce),
        .per_counter_mask_register(mask), .rx_frame(rx_frame), .tx_frame(tx_frame),
        .side_evt(side_evt), .stats_threshold_irq_flag(irq)
    );
    mms_host_model u_host (.clk(clk), .host_req(host_req), .host_rsp(host_rsp));

    // Clock and flag pulse counter
    always #2 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irq_cnt++;

    // ====================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd_chk(input logic io, input logic [8:0] a, input logic [31:0] exp);
        u_host.acc(io, 1'b0, a, 4'hf, '0, rd);
        check($sformatf("read %h io %b", a, io), exp, rd);
    endtask : rd_chk

    task automatic frame(input logic tx, input logic [47:0] dst, input logic [4:0] err);
        mms_frame_t f;
        f = {1'b1, dst, 16'h003c, 1'b1, err};
        if (tx) tx_frame = f;
        else rx_frame = f;
        @(posedge clk);
        #1;
        rx_frame = '0;
        tx_frame = '0;
        // Idle edge so that a following frame never rewrites the report at once
        @(posedge clk);
        #1;
    endtask : frame

    // Preload a counter, count one good broadcast frame, check value and flag
    task automatic bump(input logic [8:0] a, input logic [31:0] pre, input logic tx,
                        input logic [31:0] exp, input int irqs);
        int n;
        u_host.acc(1'b0, 1'b1, a, a[2] ? 4'h3 : 4'hf, pre, rd);
        n = irq_cnt;
        frame(tx, BC, 5'h0);
        rd_chk(1'b0, a, exp);
        check("flag pulses", 32'(irqs), 32'(irq_cnt - n));
    endtask : bump

    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // ====================
    // Watchdog
    initial begin
        #40000;
        fails++;
        give_verdict();
    end

    // ====================
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int a = 'ha8; a < 'h100; a += 4) rd_chk(1'b0, a[8:0], '0);
        frame(1'b0, BC, 5'h0);
        rd_chk(1'b0, 9'h0bc, 32'h1);
        rd_chk(1'b0, 9'h0b0, 32'h40);
        rd_chk(1'b0, 9'h0a8, 32'h40);
        // Unicast frame whose tag stayed in the data: octets counted as reported
        rx_frame = {1'b1, 48'h0200_0000_0001, 16'h0044, 1'b0, 5'h0};
        @(posedge clk);
        #1;
        rx_frame = '0;
        rd_chk(1'b0, 9'h0a8, 32'h84);
        for (int i = 0; i < 5; i++) frame(1'b0, BC, 5'h1 << i);
        rd_chk(1'b0, 9'h0bc, 32'h1);
        rd_chk(1'b0, 9'h0b0, 32'h40);
        // All masked, stopped, then only the frame counter masked
        mask = '1;
        frame(1'b0, BC, 5'h0);
        mask = 25'h20;
        gce = 1'b0;
        frame(1'b0, BC, 5'h0);
        gce = 1'b1;
        frame(1'b0, BC, 5'h0);
        mask = '0;
        rd_chk(1'b0, 9'h0bc, 32'h1);
        rd_chk(1'b0, 9'h0b0, 32'h80);
        bump(9'h0bc, 32'hbfff, 1'b0, 32'hc000, 1);
        bump(9'h0bc, 32'hffff, 1'b0, 32'h0, 0);
        // Sent side: broadcast, other group address, masked, stopped
        frame(1'b1, BC, 5'h0);
        frame(1'b1, MC, 5'h0);
        mask = 25'h10_0000;
        frame(1'b1, BC, 5'h0);
        mask = '0;
        gce = 1'b0;
        frame(1'b1, BC, 5'h0);
        gce = 1'b1;
        rd_chk(1'b0, 9'h0f4, 32'h1);
        bump(9'h0f4, 32'hbfff, 1'b1, 32'hc000, 1);
        bump(9'h0f4, 32'hffff, 1'b1, 32'h0, 0);
        bump(9'h0b0, 32'hbfff_ffff, 1'b0, 32'hc000_003f, 1);
        bump(9'h0b0, 32'hffff_ffc0, 1'b0, 32'h0, 0);
        // Shared slot lanes
        side_evt.rx_len_field = 1'b1;
        @(posedge clk);
        #1;
        side_evt = '0;
        rd_chk(1'b0, 9'h0c8, 32'h0001_0000);
        u_host.acc(1'b0, 1'b1, 9'h0c8, 4'hc, 32'h0005_0000, rd);
        rd_chk(1'b0, 9'h0c8, 32'h0005_0000);
        // Windows
        rd_chk(1'b1, 9'h0c8, 32'h0005_0000);
        rd_chk(1'b1, 9'h1c8, '0);
        rd_chk(1'b0, 9'h1c8, '0);
        mem_en = 1'b0;
        rd_chk(1'b0, 9'h0c8, '0);
        mem_en = 1'b1;
        io_en = 1'b0;
        rd_chk(1'b1, 9'h0c8, '0);
        io_en = 1'b1;
        give_verdict();
    end
endmodule : testbench
